// ==== design/isp_cfg_pkg.sv ====
package isp_cfg_pkg;

  // ----------------------------------------------------------------
  // Register slots
  // ----------------------------------------------------------------
  localparam int NREG_RW = 43;
  localparam int NREG    = 46;
  localparam logic [15:0] RST_VAL = 16'h0000;

  localparam int I_LUMA_PITCH   = 0;
  localparam int I_CHROMA_PITCH = 1;
  localparam int I_ROWS         = 2;
  localparam int I_COLS         = 3;
  localparam int I_STEP         = 4;
  localparam int I_BUF_A_LO     = 9;
  localparam int I_BUF_A_HI     = 10;
  localparam int I_BUF_B_LO     = 11;
  localparam int I_BUF_B_HI     = 12;
  localparam int I_CEIL         = 13;
  localparam int I_SET0_WL      = 14;
  localparam int I_SET0_SW      = 15;
  localparam int I_SET1L_S0DX   = 16;
  localparam int I_SET1_W       = 17;
  localparam int I_SET1_S       = 18;
  localparam int I_CONST_RG     = 23;
  localparam int I_CONST_B      = 24;
  localparam int I_DELTA_R      = 34;
  localparam int I_CTRL         = 37;
  localparam int I_STATUS       = 43;
  localparam int I_CNT_A        = 44;
  localparam int I_CNT_B        = 45;

  // Index of each slot; byte address is four times the index
  localparam logic [10:0] REG_IDX [NREG] = '{
    11'h524, 11'h526, 11'h528, 11'h52a, 11'h52c, 11'h52e, 11'h530, 11'h532,
    11'h534, 11'h53c, 11'h53e, 11'h540, 11'h542, 11'h544, 11'h546, 11'h548,
    11'h54a, 11'h54c, 11'h54e, 11'h550, 11'h552, 11'h554, 11'h556, 11'h558,
    11'h55a, 11'h55c, 11'h55e, 11'h560, 11'h562, 11'h564, 11'h566, 11'h568,
    11'h56a, 11'h56c, 11'h56e, 11'h570, 11'h572, 11'h500, 11'h5f0, 11'h5f2,
    11'h5f4, 11'h5f6, 11'h5f8, 11'h5fa, 11'h5fc, 11'h5fe};

  // Writable bits of each slot; read-only slots have none
  localparam logic [15:0] REG_MASK [NREG] = '{
    16'h1fff, 16'h007f, 16'h1fff, 16'h1fff, 16'hffff, 16'h7f7f, 16'h3f3f, 16'hff3f,
    16'hffff, 16'hffff, 16'h007f, 16'hffff, 16'h007f, 16'h00ff, 16'h7fff, 16'h3f1f,
    16'hff3f, 16'h1f7f, 16'h3f3f, 16'h03ff, 16'h03ff, 16'h03ff, 16'h03ff, 16'hffff,
    16'h00ff, 16'h1fff, 16'h1fff, 16'h1fff, 16'h1fff, 16'h1fff, 16'h1fff, 16'h1fff,
    16'h1fff, 16'h1fff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h0c00, 16'h03ff, 16'h03ff,
    16'h03ff, 16'h03ff, 16'h03ff, 16'h0000, 16'h0000, 16'h0000};

  // Matrix slots in row-major order
  localparam int CSC_SLOT [9] = '{19, 38, 39, 20, 40, 41, 21, 42, 22};
  localparam int CC_SLOT  [9] = '{25, 26, 27, 28, 29, 30, 31, 32, 33};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_CC_EN_BIT   = 10;
  localparam int CTRL_STAT_EN_BIT = 11;
  localparam int STEP_V_LSB       = 8;
  localparam int STEP_H_LSB       = 0;
  localparam int HI_FIELD_LSB     = 8;
  localparam int FRAC_BITS        = 8;
  localparam int STEP_FRAC_BITS   = 2;
  localparam logic [9:0] CHROMA_MID = 10'h080;

  // ----------------------------------------------------------------
  // Pixel carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic       eof;
    logic [7:0] y;
    logic [7:0] u;
    logic [7:0] v;
  } yuv_pix_t;

  typedef struct packed {
    logic       valid;
    logic       eof;
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } rgb_pix_t;

endpackage

// ==== design/pixel_mac3.sv ====
`timescale 1ns/1ps
`default_nettype none

module pixel_mac3 #(
  parameter int CW   = 13,
  parameter int FRAC = 8
) (
  input  wire logic            clk_in,
  input  wire logic            rst_in,
  input  wire logic [3*CW-1:0] coef_in,
  input  wire logic [29:0]     vec_in,
  input  wire logic [9:0]      ofs_in,
  input  wire logic            bypass_in,
  input  wire logic [7:0]      pass_in,
  output logic      [7:0]      res_out
);

  localparam int SW = CW + 12;

  if (CW < 2 || FRAC >= CW + 8) begin : g_bad
    $error("pixel_mac3: unsupported coefficient format");
  end

  logic signed [SW-1:0] sum;
  logic signed [SW-1:0] scaled;
  logic        [7:0]    res_d;

  // Products summed at full width, offset aligned to the fraction point
  always_comb begin
    sum = SW'($signed(ofs_in)) <<< FRAC;
    for (int k = 0; k < 3; k++) begin
      sum = sum + SW'($signed(coef_in[k*CW +: CW])) * SW'($signed(vec_in[k*10 +: 10]));
    end
    scaled = sum >>> FRAC;
  end

  assign res_d = bypass_in ? pass_in :
                 (scaled < 0) ? 8'h00 :
                 (scaled > SW'(255)) ? 8'hff : scaled[7:0];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      res_out <= 8'h00;
    end else begin
      res_out <= res_d;
    end
  end

endmodule

`default_nettype wire

// ==== design/isp_decode_stat_color_regs.sv ====
// Operation
// - Hold 13-bit luma pitch, input rows and columns; step line fetch by them.
// - Hold 7-bit chroma line pitch in low bits; step chroma fetch by it.
// - Step on-the-fly sampling position per block by 6.2 increments.
// - Write statistics to two buffers alternately, each with 23-bit base.
// - Skip pixels whose luma exceeds the white ceiling.
// - Evaluate two independent white sets: floor, two widths, two shifts.
// - Convert YUV to RGB through 3x3 10-bit matrix plus RGB constants.
// - Treat correction coefficients as 13-bit signed, eight fraction bits.
// - Correct RGB by 3x3 matrix plus signed 8-bit offsets.
// - Correct only while enable bit set; otherwise pass pixels unchanged.
`timescale 1ns/1ps
`default_nettype none

module isp_decode_stat_color_regs #(
  parameter int ADDR_W = 13
) (
  input  wire logic                     MCLK_IN,
  input  wire logic                     RST_IN,
  input  wire logic [ADDR_W-1:0]        AVS_ADDRESS_IN,
  input  wire logic                     AVS_READ_IN,
  input  wire logic                     AVS_WRITE_IN,
  input  wire logic [3:0]               AVS_BYTEENABLE_IN,
  input  wire logic [31:0]              AVS_WRITEDATA_IN,
  output logic      [31:0]              AVS_READDATA_OUT,
  output logic                          AVS_WAITREQUEST_OUT,
  input  wire logic                     FRAME_START_IN,
  input  wire logic                     LINE_NEXT_IN,
  input  wire logic                     BLOCK_NEXT_IN,
  input  wire logic                     BLOCK_ROW_IN,
  input  wire isp_cfg_pkg::yuv_pix_t    PIX_IN,
  output var isp_cfg_pkg::rgb_pix_t     PIX_OUT,
  output logic      [22:0]              LUMA_LINE_OFS_OUT,
  output logic      [22:0]              CHROMA_LINE_OFS_OUT,
  output logic                          LAST_ROW_OUT,
  output logic      [12:0]              LINE_COLS_OUT,
  output logic      [13:0]              STREAMING_BLOCK_MODE_X_OUT,
  output logic      [13:0]              STREAMING_BLOCK_MODE_Y_OUT,
  output logic      [22:0]              STAT_BASE_OUT
);

  if (ADDR_W != 13) begin : g_bad
    $error("isp_decode_stat_color_regs: ADDR_W must be 13");
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic [15:0] regs_q [isp_cfg_pkg::NREG_RW];
  logic [15:0] rd_val [isp_cfg_pkg::NREG];
  logic [isp_cfg_pkg::NREG-1:0] hit;
  logic        waitreq_q;
  logic [15:0] rdata_q;
  logic [15:0] rd_mux;
  logic [15:0] be_mask;
  wire         req     = AVS_READ_IN | AVS_WRITE_IN;
  wire         wr_fire = AVS_WRITE_IN & ~waitreq_q;

  assign be_mask = {{8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};

  for (genvar i = 0; i < isp_cfg_pkg::NREG; i++) begin : g_dec
    assign hit[i] = (AVS_ADDRESS_IN[12:2] == isp_cfg_pkg::REG_IDX[i]) &&
                    (AVS_ADDRESS_IN[1:0] == 2'h0);
  end

  // Storage only for writable bits, so reserved bits read as zero
  for (genvar i = 0; i < isp_cfg_pkg::NREG_RW; i++) begin : g_reg
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
        regs_q[i] <= isp_cfg_pkg::RST_VAL;
      end else if (wr_fire && hit[i]) begin
        regs_q[i] <= ((regs_q[i] & ~be_mask) | (AVS_WRITEDATA_IN[15:0] & be_mask))
                     & isp_cfg_pkg::REG_MASK[i];
      end
    end
    assign rd_val[i] = regs_q[i];
  end

  // Unmapped addresses read as zero and ignore writes
  always_comb begin
    rd_mux = 16'h0000;
    for (int i = 0; i < isp_cfg_pkg::NREG; i++) begin
      rd_mux = rd_mux | (hit[i] ? rd_val[i] : 16'h0000);
    end
  end

  // One wait cycle on every access; data stands while waitrequest is low
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      waitreq_q <= 1'b1;
      rdata_q   <= 16'h0000;
    end else begin
      waitreq_q <= ~(req & waitreq_q);
      if (AVS_READ_IN && waitreq_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign AVS_WAITREQUEST_OUT = waitreq_q;
  assign AVS_READDATA_OUT    = {16'h0000, rdata_q};

  // ----------------------------------------------------------------
  // Field views
  // ----------------------------------------------------------------
  wire        cc_en   = regs_q[isp_cfg_pkg::I_CTRL][isp_cfg_pkg::CTRL_CC_EN_BIT];
  wire        stat_en = regs_q[isp_cfg_pkg::I_CTRL][isp_cfg_pkg::CTRL_STAT_EN_BIT];
  wire [12:0] luma_pitch   = regs_q[isp_cfg_pkg::I_LUMA_PITCH][12:0];
  wire [6:0]  chroma_pitch = regs_q[isp_cfg_pkg::I_CHROMA_PITCH][6:0];
  wire [12:0] rows         = regs_q[isp_cfg_pkg::I_ROWS][12:0];
  wire [7:0]  step_v = regs_q[isp_cfg_pkg::I_STEP][isp_cfg_pkg::STEP_V_LSB +: 8];
  wire [7:0]  step_h = regs_q[isp_cfg_pkg::I_STEP][isp_cfg_pkg::STEP_H_LSB +: 8];
  wire [22:0] buf_a  = {regs_q[isp_cfg_pkg::I_BUF_A_HI][6:0],
                        regs_q[isp_cfg_pkg::I_BUF_A_LO]};
  wire [22:0] buf_b  = {regs_q[isp_cfg_pkg::I_BUF_B_HI][6:0],
                        regs_q[isp_cfg_pkg::I_BUF_B_LO]};
  wire [7:0]  ceil   = regs_q[isp_cfg_pkg::I_CEIL][7:0];

  logic [7:0] floor_s [2];
  logic [6:0] w1_s    [2];
  logic [4:0] w2_s    [2];
  logic [5:0] dx_s    [2];
  logic [5:0] dy_s    [2];
  assign floor_s[0] = regs_q[isp_cfg_pkg::I_SET0_WL][7:0];
  assign w1_s[0]    = regs_q[isp_cfg_pkg::I_SET0_WL][14:8];
  assign w2_s[0]    = regs_q[isp_cfg_pkg::I_SET0_SW][4:0];
  assign dy_s[0]    = regs_q[isp_cfg_pkg::I_SET0_SW][13:8];
  assign dx_s[0]    = regs_q[isp_cfg_pkg::I_SET1L_S0DX][5:0];
  assign floor_s[1] = regs_q[isp_cfg_pkg::I_SET1L_S0DX][15:8];
  assign w1_s[1]    = regs_q[isp_cfg_pkg::I_SET1_W][6:0];
  assign w2_s[1]    = regs_q[isp_cfg_pkg::I_SET1_W][12:8];
  assign dy_s[1]    = regs_q[isp_cfg_pkg::I_SET1_S][5:0];
  assign dx_s[1]    = regs_q[isp_cfg_pkg::I_SET1_S][13:8];

  // ----------------------------------------------------------------
  // Decoder line fetch
  // ----------------------------------------------------------------
  logic [12:0] row_q;
  logic [22:0] luma_ofs_q;
  logic [22:0] chroma_ofs_q;
  logic        last_row_q;
  wire         line_adv = LINE_NEXT_IN & ~FRAME_START_IN & (row_q < rows - 13'h0001);
  wire  [12:0] row_d    = FRAME_START_IN ? 13'h0000 : line_adv ? row_q + 13'h0001 : row_q;

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      row_q        <= 13'h0000;
      luma_ofs_q   <= 23'h000000;
      chroma_ofs_q <= 23'h000000;
      last_row_q   <= 1'b0;
    end else begin
      row_q      <= row_d;
      last_row_q <= (row_d == rows - 13'h0001);
      if (FRAME_START_IN) begin
        luma_ofs_q   <= 23'h000000;
        chroma_ofs_q <= 23'h000000;
      end else if (line_adv) begin
        luma_ofs_q   <= luma_ofs_q + {10'h000, luma_pitch};
        chroma_ofs_q <= chroma_ofs_q + {16'h0000, chroma_pitch};
      end
    end
  end

  // ----------------------------------------------------------------
  // On-the-fly block position
  // ----------------------------------------------------------------
  logic [15:0] pos_x_q;
  logic [15:0] pos_y_q;

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pos_x_q <= 16'h0000;
      pos_y_q <= 16'h0000;
    end else if (FRAME_START_IN) begin
      pos_x_q <= 16'h0000;
      pos_y_q <= 16'h0000;
    end else if (BLOCK_ROW_IN) begin
      pos_x_q <= 16'h0000;
      pos_y_q <= pos_y_q + {8'h00, step_v};
    end else if (BLOCK_NEXT_IN) begin
      pos_x_q <= pos_x_q + {8'h00, step_h};
    end
  end

  // ----------------------------------------------------------------
  // White statistics
  // ----------------------------------------------------------------
  logic [15:0] cnt_q [2];
  logic [15:0] res_q [2];
  logic [1:0]  hit_s;
  logic        buf_sel_q;
  logic [22:0] stat_base_q;
  wire         frame_end = PIX_IN.valid & PIX_IN.eof;
  wire signed [9:0] u_c = $signed({2'b00, PIX_IN.u} - isp_cfg_pkg::CHROMA_MID);
  wire signed [9:0] v_c = $signed({2'b00, PIX_IN.v} - isp_cfg_pkg::CHROMA_MID);

  for (genvar s = 0; s < 2; s++) begin : g_set
    wire signed [9:0] du = u_c - 10'($signed(dx_s[s]));
    wire signed [9:0] dv = v_c - 10'($signed(dy_s[s]));
    wire        [9:0] au = du[9] ? 10'(-du) : du;
    wire        [9:0] av = dv[9] ? 10'(-dv) : dv;
    assign hit_s[s] = stat_en && PIX_IN.valid && (PIX_IN.y <= ceil) &&
                      (PIX_IN.y >= floor_s[s]) && (au <= {3'b000, w1_s[s]}) &&
                      (av <= {5'b00000, w2_s[s]});

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
        cnt_q[s] <= 16'h0000;
        res_q[s] <= 16'h0000;
      end else if (frame_end) begin
        res_q[s] <= cnt_q[s] + {15'h0000, hit_s[s]};
        cnt_q[s] <= 16'h0000;
      end else begin
        cnt_q[s] <= cnt_q[s] + {15'h0000, hit_s[s]};
      end
    end
  end

  // Finished results stay readable while the other buffer fills
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      buf_sel_q   <= 1'b0;
      stat_base_q <= 23'h000000;
    end else begin
      if (frame_end && stat_en) begin
        buf_sel_q <= ~buf_sel_q;
      end
      stat_base_q <= buf_sel_q ? buf_b : buf_a;
    end
  end

  assign rd_val[isp_cfg_pkg::I_STATUS] = {15'h0000, buf_sel_q};
  assign rd_val[isp_cfg_pkg::I_CNT_A]  = res_q[0];
  assign rd_val[isp_cfg_pkg::I_CNT_B]  = res_q[1];

  // ----------------------------------------------------------------
  // Colour pipeline
  // ----------------------------------------------------------------
  logic [7:0]  csc_rgb [3];
  logic [7:0]  cc_rgb  [3];
  logic [1:0]  vld_q;
  logic [1:0]  eof_q;
  logic [29:0] yuv_vec;
  logic [29:0] rgb_vec;
  logic [9:0]  csc_const [3];
  logic [9:0]  cc_delta  [3];

  assign yuv_vec = {v_c, u_c, {2'b00, PIX_IN.y}};
  assign rgb_vec = {{2'b00, csc_rgb[2]}, {2'b00, csc_rgb[1]}, {2'b00, csc_rgb[0]}};
  assign csc_const[0] = {2'b00, regs_q[isp_cfg_pkg::I_CONST_RG][15:8]};
  assign csc_const[1] = {2'b00, regs_q[isp_cfg_pkg::I_CONST_RG][7:0]};
  assign csc_const[2] = {2'b00, regs_q[isp_cfg_pkg::I_CONST_B][7:0]};

  for (genvar c = 0; c < 3; c++) begin : g_ch
    wire [7:0] dl = regs_q[isp_cfg_pkg::I_DELTA_R + c][7:0];
    assign cc_delta[c] = {{2{dl[7]}}, dl};

    pixel_mac3 #(.CW(10), .FRAC(isp_cfg_pkg::FRAC_BITS)) u_csc (
      .clk_in   (MCLK_IN),
      .rst_in   (RST_IN),
      .coef_in  ({regs_q[isp_cfg_pkg::CSC_SLOT[3*c+2]][9:0],
                  regs_q[isp_cfg_pkg::CSC_SLOT[3*c+1]][9:0],
                  regs_q[isp_cfg_pkg::CSC_SLOT[3*c]][9:0]}),
      .vec_in   (yuv_vec),
      .ofs_in   (csc_const[c]),
      .bypass_in(1'b0),
      .pass_in  (8'h00),
      .res_out  (csc_rgb[c])
    );

    pixel_mac3 #(.CW(13), .FRAC(isp_cfg_pkg::FRAC_BITS)) u_cc (
      .clk_in   (MCLK_IN),
      .rst_in   (RST_IN),
      .coef_in  ({regs_q[isp_cfg_pkg::CC_SLOT[3*c+2]][12:0],
                  regs_q[isp_cfg_pkg::CC_SLOT[3*c+1]][12:0],
                  regs_q[isp_cfg_pkg::CC_SLOT[3*c]][12:0]}),
      .vec_in   (rgb_vec),
      .ofs_in   (cc_delta[c]),
      .bypass_in(~cc_en),
      .pass_in  (csc_rgb[c]),
      .res_out  (cc_rgb[c])
    );
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      vld_q <= 2'b00;
      eof_q <= 2'b00;
    end else begin
      vld_q <= {vld_q[0], PIX_IN.valid};
      eof_q <= {eof_q[0], PIX_IN.valid & PIX_IN.eof};
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign PIX_OUT             = '{valid: vld_q[1], eof: eof_q[1],
                                 r: cc_rgb[0], g: cc_rgb[1], b: cc_rgb[2]};
  assign LUMA_LINE_OFS_OUT   = luma_ofs_q;
  assign CHROMA_LINE_OFS_OUT = chroma_ofs_q;
  assign LAST_ROW_OUT        = last_row_q;
  assign LINE_COLS_OUT       = regs_q[isp_cfg_pkg::I_COLS][12:0];
  assign STREAMING_BLOCK_MODE_X_OUT         = pos_x_q[15:isp_cfg_pkg::STEP_FRAC_BITS];
  assign STREAMING_BLOCK_MODE_Y_OUT         = pos_y_q[15:isp_cfg_pkg::STEP_FRAC_BITS];
  assign STAT_BASE_OUT       = stat_base_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);

  sequence s_frame_end;
    frame_end && stat_en;
  endsequence

  sequence s_swap;
    (buf_sel_q != $past(buf_sel_q)) ##1 (stat_base_q == (buf_sel_q ? buf_b : buf_a));
  endsequence

  chk_luma_step: assert property (
    line_adv |=> luma_ofs_q == $past(luma_ofs_q) + {10'h000, $past(luma_pitch)})
    else $error("luma line offset did not step by pitch");

  chk_chroma_step: assert property (
    line_adv |=> chroma_ofs_q == $past(chroma_ofs_q) + {16'h0000, $past(chroma_pitch)})
    else $error("chroma line offset did not step by pitch");

  chk_streaming_block_mode_step: assert property (
    BLOCK_NEXT_IN && !BLOCK_ROW_IN && !FRAME_START_IN
    |=> pos_x_q == $past(pos_x_q) + {8'h00, $past(step_h)})
    else $error("block position did not step");

  chk_buffer_swap: assert property (
    s_frame_end |=> s_swap)
    else $error("statistics buffer did not alternate");

  chk_luma_ceiling: assert property (
    PIX_IN.valid && !PIX_IN.eof && PIX_IN.y > ceil |=> cnt_q[0] == $past(cnt_q[0]))
    else $error("pixel above ceiling was counted");

  chk_set_latch: assert property (
    frame_end |=> res_q[1] == $past(cnt_q[1]) + 16'($past(hit_s[1])) && cnt_q[1] == 16'h0000)
    else $error("set result not latched at frame end");

  chk_pipe_timing: assert property (
    PIX_IN.valid |-> ##2 PIX_OUT.valid)
    else $error("pixel did not leave after two cycles");

  chk_cc_bypass: assert property (
    !cc_en && vld_q[0] |=> PIX_OUT.r == $past(csc_rgb[0]) && PIX_OUT.b == $past(csc_rgb[2]))
    else $error("disabled correction changed the pixel");

endmodule

`default_nettype wire

// ==== dv/isp_decode_stat_color_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("ERROR %0t mismatch got %h exp %h", $time, got, exp); end end

module isp_decode_stat_color_regs_tb;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic [12:0]           addr = '0;
  logic                  rd = 1'b0;
  logic                  wr = 1'b0;
  logic [31:0]           wdata = '0;
  logic [31:0]           rdata;
  logic                  waitreq;
  logic [3:0]            ctl = '0;
  isp_cfg_pkg::yuv_pix_t pix = '0;
  isp_cfg_pkg::rgb_pix_t pout;
  logic [22:0]           luma_ofs, chroma_ofs, sbase;
  logic                  last_row;
  logic [12:0]           cols;
  logic [13:0]           ox, oy;
  logic [15:0]           q, d;
  int                    n_mismatch = 0, num_checks = 0;
  int                    cst[3], dlt[3];
  int                    p, c, y, sx, sy, ceil, ca, cb, e;

  isp_decode_stat_color_regs dut_u (.MCLK_IN(clk), .RST_IN(rst), .AVS_ADDRESS_IN(addr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_BYTEENABLE_IN(4'hf), .AVS_WRITEDATA_IN(wdata),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq), .FRAME_START_IN(ctl[3]),
    .LINE_NEXT_IN(ctl[2]), .BLOCK_NEXT_IN(ctl[1]), .BLOCK_ROW_IN(ctl[0]), .PIX_IN(pix),
    .PIX_OUT(pout), .LUMA_LINE_OFS_OUT(luma_ofs), .CHROMA_LINE_OFS_OUT(chroma_ofs),
    .LAST_ROW_OUT(last_row), .LINE_COLS_OUT(cols), .STREAMING_BLOCK_MODE_X_OUT(ox), .STREAMING_BLOCK_MODE_Y_OUT(oy),
    .STAT_BASE_OUT(sbase));

  always #2 clk = ~clk;

  // ----------------------------------------------------------------
  // Bus and stimulus helpers
  // ----------------------------------------------------------------
  // Request held until waitrequest is seen low; the slave sets the pace
  task automatic bus(input logic w, input logic [10:0] idx, input logic [15:0] wd);
    int n;
    @(posedge clk);
    addr <= {idx, 2'b00}; rd <= ~w; wr <= w; wdata <= {16'h0000, wd};
    n = 0;
    do begin @(posedge clk); n++; end while (waitreq !== 1'b0 && n < 50);
    if (n >= 50) begin n_mismatch++; $display("ERROR %0t bus hang", $time); end
    q = rdata[15:0];
    rd <= 1'b0;
    wr <= 1'b0;
    // Let the write land before the caller looks at outputs
    #1;
  endtask

  task automatic pulse(input logic [3:0] m);
    @(posedge clk); ctl <= m;
    @(posedge clk); ctl <= 4'h0;
    #1;
  endtask

  task automatic send(input int yv, input logic eof, input logic [7:0] uv = 8'h80);
    @(posedge clk); pix <= '{valid: 1'b1, eof: eof, y: 8'(yv), u: uv, v: uv};
  endtask

  function automatic logic [7:0] clampv(input int x);
    return x < 0 ? 8'h00 : (x > 255 ? 8'hff : 8'(x));
  endfunction

  function automatic logic [24:0] exp_pix(input int yv, input bit en);
    logic [23:0] res;
    logic [7:0]  v;
    res = '0;
    for (int k = 0; k < 3; k++) begin
      v = clampv(yv + cst[k]);
      if (en) v = clampv(int'(v) + dlt[k]);
      res = {res[15:0], v};
    end
    return {1'b1, res};
  endfunction

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #40000;
    n_mismatch++;
    $display("ERROR %0t watchdog expired", $time);
    stop_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hfb1cbe6a));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < isp_cfg_pkg::NREG; i++) begin
      bus(1'b0, isp_cfg_pkg::REG_IDX[i], 16'h0000);
      `CHK(q, isp_cfg_pkg::RST_VAL)
    end
    for (int i = 0; i < isp_cfg_pkg::NREG_RW; i++) begin
      d = 16'($urandom);
      bus(1'b1, isp_cfg_pkg::REG_IDX[i], d);
      bus(1'b0, isp_cfg_pkg::REG_IDX[i], 16'h0000);
      `CHK(q, d & isp_cfg_pkg::REG_MASK[i])
    end
    bus(1'b1, 11'h536, 16'hffff);
    bus(1'b0, 11'h536, 16'h0000);
    `CHK(q, 16'h0000)
    $display("register test done");
    // Reset again mid-run so the functional tests start from zero
    @(posedge clk); rst <= 1'b1;
    repeat (2) @(posedge clk); rst <= 1'b0;
    bus(1'b0, isp_cfg_pkg::REG_IDX[isp_cfg_pkg::I_STEP], 16'h0000);
    `CHK(q, 16'h0000)
    p = $urandom & 32'h1fff; c = $urandom & 32'h7f; e = $urandom & 32'h1fff;
    bus(1'b1, isp_cfg_pkg::REG_IDX[isp_cfg_pkg::I_LUMA_PITCH], 16'(p));
    bus(1'b1, isp_cfg_pkg::REG_IDX[isp_cfg_pkg::I_CHROMA_PITCH], 16'(c));
    bus(1'b1, isp_cfg_pkg::REG_IDX[isp_cfg_pkg::I_ROWS], 16'h0003);
    bus(1'b1, isp_cfg_pkg::REG_IDX[isp_cfg_pkg::I_COLS], 16'(e));
    `CHK(cols, 13'(e))
    pulse(4'h8);
    `CHK(luma_ofs, 23'h0)
    for (int k = 1; k <= 3; k++) begin
      pulse(4'h4);
      `CHK(luma_ofs, 23'((k > 2 ? 2 : k) * p))
      `CHK(chroma_ofs, 23'((k > 2 ? 2 : k) * c))
      `CHK(last_row, 1'(k >= 2))
    end
    sx = $urandom & 32'hff; sy = $urandom & 32'hff;
    bus(1'b1, isp_cfg_pkg::REG_IDX[isp_cfg_pkg::I_STEP], 16'(sy * 256 + sx));
    pulse(4'h8);
    for (int k = 1; k <= 3; k++) begin
      pulse(4'h2);
      `CHK(ox, 14'((k * sx) >> 2))
    end
    pulse(4'h1);
    `CHK({ox, oy}, {14'h0, 14'(sy >> 2)})
    pulse(4'h3);
    `CHK({ox, oy}, {14'h0, 14'((2 * sy) >> 2)})
    $display("fetch test done");
    for (int k = 0; k < 3; k++) begin
      cst[k] = $urandom & 32'hff;
      dlt[k] = int'($signed(8'($urandom)));
      bus(1'b1, isp_cfg_pkg::REG_IDX[isp_cfg_pkg::CSC_SLOT[3 * k]], 16'h0100);
      bus(1'b1, isp_cfg_pkg::REG_IDX[isp_cfg_pkg::CC_SLOT[4 * k]], 16'h0100);
      bus(1'b1, isp_cfg_pkg::REG_IDX[isp_cfg_pkg::I_DELTA_R + k], 16'(dlt[k] & 255));
    end
    bus(1'b1, isp_cfg_pkg::REG_IDX[isp_cfg_pkg::I_CONST_RG], 16'(cst[0] * 256 + cst[1]));
    bus(1'b1, isp_cfg_pkg::REG_IDX[isp_cfg_pkg::I_CONST_B], 16'(cst[2]));
    for (int en = 0; en < 2; en++) begin
      bus(1'b1, isp_cfg_pkg::REG_IDX[isp_cfg_pkg::I_CTRL], en ? 16'h0400 : 16'h0000);
      for (int t = 0; t < 6; t++) begin
        y = (t == 0) ? 0 : ((t == 1) ? 255 : ($urandom & 32'hff));
        send(y, 1'b0);
        @(posedge clk); pix <= '0;
        // Result stands for one cycle only
        @(posedge clk);
        #1;
        `CHK({pout.valid, pout.r, pout.g, pout.b}, exp_pix(y, en[0]))
      end
    end
    $display("colour test done");
    ceil = 100 + ($urandom % 100); ca = 0; cb = 0;
    p = $urandom & 32'h7fffff; c = $urandom & 32'h7fffff;
    bus(1'b1, isp_cfg_pkg::REG_IDX[isp_cfg_pkg::I_BUF_A_LO], 16'(p));
    bus(1'b1, isp_cfg_pkg::REG_IDX[isp_cfg_pkg::I_BUF_A_HI], 16'(p >> 16));
    bus(1'b1, isp_cfg_pkg::REG_IDX[isp_cfg_pkg::I_BUF_B_LO], 16'(c));
    bus(1'b1, isp_cfg_pkg::REG_IDX[isp_cfg_pkg::I_BUF_B_HI], 16'(c >> 16));
    bus(1'b1, isp_cfg_pkg::REG_IDX[isp_cfg_pkg::I_CEIL], 16'(ceil));
    bus(1'b1, isp_cfg_pkg::REG_IDX[isp_cfg_pkg::I_SET0_WL], 16'h7f00);
    bus(1'b1, isp_cfg_pkg::REG_IDX[isp_cfg_pkg::I_SET0_SW], 16'h001f);
    bus(1'b1, isp_cfg_pkg::REG_IDX[isp_cfg_pkg::I_SET1L_S0DX], 16'h3200);
    bus(1'b1, isp_cfg_pkg::REG_IDX[isp_cfg_pkg::I_CTRL], 16'h0800);
    `CHK(sbase, 23'(p))
    // Pixel two lies outside both colour windows
    for (int t = 0; t < 20; t++) begin
      y = (t == 0) ? ceil : ((t == 1) ? ceil + 1 : ($urandom & 32'hff));
      ca += (y <= ceil && t != 2);
      cb += (y >= 50 && y <= ceil && t != 2);
      send(y, t == 19, (t == 2) ? 8'h00 : 8'h80);
    end
    @(posedge clk); pix <= '0;
    @(posedge clk);
    #1;
    `CHK({pout.valid, pout.eof}, 2'b11)
    `CHK(sbase, 23'(c))
    bus(1'b0, isp_cfg_pkg::REG_IDX[isp_cfg_pkg::I_STATUS], 16'h0000);
    `CHK(q[0], 1'b1)
    bus(1'b0, isp_cfg_pkg::REG_IDX[isp_cfg_pkg::I_CNT_A], 16'h0000);
    `CHK(q, 16'(ca))
    bus(1'b0, isp_cfg_pkg::REG_IDX[isp_cfg_pkg::I_CNT_B], 16'h0000);
    `CHK(q, 16'(cb))
    $display("statistics test done");
    stop_test();
  end
endmodule

`default_nettype wire
